// ### irsr_defs.svh
`ifndef IRSR_DEFS_SVH
`define IRSR_DEFS_SVH

// ----------------------------------------------------------------
// Primary line numbers
// ----------------------------------------------------------------
`define IRSR_P_BUS_ERR     1
`define IRSR_P_UART2       2
`define IRSR_P_UART1       3
`define IRSR_P_PIO_LOW     4
`define IRSR_P_TIMER1      8
`define IRSR_P_TIMER2      9
`define IRSR_P_SECOND      10
`define IRSR_P_TRACE       11
`define IRSR_P_CAN         12
`define IRSR_P_SPW0        13
`define IRSR_P_SPW1        14
`define IRSR_P_PIO7        15

// ----------------------------------------------------------------
// Secondary line numbers
// ----------------------------------------------------------------
`define IRSR_S_PULSE       1
`define IRSR_S_GTIMER1     2
`define IRSR_S_GTIMER2     3
`define IRSR_S_ADC         4
`define IRSR_S_DAC         5
`define IRSR_S_TX_DONE     6
`define IRSR_S_TX_EMPTY    7
`define IRSR_S_TX_FAULT    8
`define IRSR_S_RX_DONE     9
`define IRSR_S_RX_FULL     10
`define IRSR_S_RX_FAULT    11
`define IRSR_S_RX_PARITY   12
`define IRSR_S_SPW0_IRQ    13
`define IRSR_S_SPW0_TICK   14
`define IRSR_S_SPW1_IRQ    15
`define IRSR_S_SPW1_TICK   16
`define IRSR_S_CAN_IRQ     17
`define IRSR_S_CAN_SENT    18
`define IRSR_S_CAN_RCVD    19
`define IRSR_S_GPIO_LOW    24
`define IRSR_GPIO_FIRST    16

// ----------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------
`define IRSR_SEC_USED      32'hFF0F_FFFE
`define IRSR_RST_PEND      32'h0000_0000
`define IRSR_RST_PRIM      16'h0000

`endif

// ### irsr_pkg.sv
package irsr_pkg;

    typedef struct packed {
        logic [31:0] prev;
        logic [31:0] pending;
        logic        irq;
    } irsr_sec_state_t;

    typedef struct packed {
        logic [31:0] sec_src;
        logic [15:0] prim;
    } irsr_top_state_t;

endpackage

// ### irsr_sec_ctrl.sv
`timescale 1ns/1ps
`include "irsr_defs.svh"

module irsr_sec_ctrl
    import irsr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [31:0] src,
    input  wire logic [31:0] mask,
    input  wire logic [31:0] clear,
    output logic      [31:0] pending,
    output logic             irq
);

    irsr_sec_state_t st;
    irsr_sec_state_t next_st;
    logic [31:0]     rise;

    // ----------------------------------------------------------------
    // Edge capture
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        rise = src & ~st.prev & `IRSR_SEC_USED;
        next_st.prev = src;
        next_st.pending = (st.pending & ~clear) | rise;
        next_st.irq = |(next_st.pending & mask);
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st.prev    <= 32'h0000_0000;
            st.pending <= `IRSR_RST_PEND;
            st.irq     <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign pending = st.pending;
    assign irq     = st.irq;

endmodule

// ### irsr_top.sv
`timescale 1ns/1ps
`include "irsr_defs.svh"

module irsr_top
    import irsr_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  pio_irq,
    input  wire logic        spw1_irq,
    input  wire logic        spw0_irq,
    input  wire logic        can_irq,
    input  wire logic        trace_irq,
    input  wire logic        timer2_irq,
    input  wire logic        timer1_irq,
    input  wire logic        uart1_irq,
    input  wire logic        uart2_irq,
    input  wire logic        bus_err_irq,
    input  wire logic [23:0] gpio_irq,
    input  wire logic        can_sync_received,
    input  wire logic        can_sync_sent,
    input  wire logic        spw1_tick,
    input  wire logic        spw0_tick,
    input  wire logic        fifo_rx_parity_fault,
    input  wire logic        fifo_rx_bus_fault,
    input  wire logic        fifo_rx_ring_full,
    input  wire logic        fifo_rx_block_done,
    input  wire logic        fifo_tx_bus_fault,
    input  wire logic        fifo_tx_ring_empty,
    input  wire logic        fifo_tx_block_done,
    input  wire logic        dac_ready,
    input  wire logic        adc_ready,
    input  wire logic        gtimer2_expired,
    input  wire logic        gtimer1_expired,
    input  wire logic        pulse_done,
    input  wire logic [31:0] sec_mask,
    input  wire logic [31:0] sec_clear,
    output logic      [15:0] prim_irq,
    output logic      [31:0] sec_pending
);

    irsr_top_state_t st;
    irsr_top_state_t next_st;
    logic            sec_irq;

    // ----------------------------------------------------------------
    // Line assembly
    // ----------------------------------------------------------------
    function automatic logic [31:0] sec_vector(
        input logic [23:0] gpio,
        input logic [18:0] ev
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        v[19:1] = ev;
        v[31:`IRSR_S_GPIO_LOW] = gpio[23:`IRSR_GPIO_FIRST];
        return v & `IRSR_SEC_USED;
    endfunction

    always_comb begin
        logic [18:0] ev;
        ev = 19'h0_0000;
        next_st = st;
        ev[`IRSR_S_PULSE-1]     = pulse_done;
        ev[`IRSR_S_GTIMER1-1]   = gtimer1_expired;
        ev[`IRSR_S_GTIMER2-1]   = gtimer2_expired;
        ev[`IRSR_S_ADC-1]       = adc_ready;
        ev[`IRSR_S_DAC-1]       = dac_ready;
        ev[`IRSR_S_TX_DONE-1]   = fifo_tx_block_done;
        ev[`IRSR_S_TX_EMPTY-1]  = fifo_tx_ring_empty;
        ev[`IRSR_S_TX_FAULT-1]  = fifo_tx_bus_fault;
        ev[`IRSR_S_RX_DONE-1]   = fifo_rx_block_done;
        ev[`IRSR_S_RX_FULL-1]   = fifo_rx_ring_full;
        ev[`IRSR_S_RX_FAULT-1]  = fifo_rx_bus_fault;
        ev[`IRSR_S_RX_PARITY-1] = fifo_rx_parity_fault;
        ev[`IRSR_S_SPW0_IRQ-1]  = spw0_irq;
        ev[`IRSR_S_SPW0_TICK-1] = spw0_tick;
        ev[`IRSR_S_SPW1_IRQ-1]  = spw1_irq;
        ev[`IRSR_S_SPW1_TICK-1] = spw1_tick;
        ev[`IRSR_S_CAN_IRQ-1]   = can_irq;
        ev[`IRSR_S_CAN_SENT-1]  = can_sync_sent;
        ev[`IRSR_S_CAN_RCVD-1]  = can_sync_received;
        next_st.sec_src = sec_vector(gpio_irq, ev);

        // Level pass-through, so no event is ever latched and lost
        next_st.prim = 16'h0000;
        next_st.prim[`IRSR_P_BUS_ERR] = bus_err_irq;
        next_st.prim[`IRSR_P_UART2]   = uart2_irq;
        next_st.prim[`IRSR_P_UART1]   = uart1_irq;
        next_st.prim[`IRSR_P_TIMER1]  = timer1_irq;
        next_st.prim[`IRSR_P_TIMER2]  = timer2_irq;
        next_st.prim[`IRSR_P_TRACE]   = trace_irq;
        next_st.prim[`IRSR_P_PIO_LOW+:4] = pio_irq[3:0];
        next_st.prim[`IRSR_P_SECOND] = sec_irq | pio_irq[4];
        next_st.prim[`IRSR_P_CAN]  = can_irq | pio_irq[5];
        next_st.prim[`IRSR_P_SPW0] = spw0_irq | pio_irq[6];
        next_st.prim[`IRSR_P_SPW1] = spw1_irq;
        next_st.prim[`IRSR_P_PIO7] = pio_irq[7];
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st.sec_src <= 32'h0000_0000;
            st.prim    <= `IRSR_RST_PRIM;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // Secondary controller
    // ----------------------------------------------------------------
    // Registered source adds one cycle but keeps edge logic off raw pins
    irsr_sec_ctrl u_sec (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .src     (st.sec_src),
        .mask    (sec_mask),
        .clear   (sec_clear),
        .pending (sec_pending),
        .irq     (sec_irq)
    );

    assign prim_irq = st.prim;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    chk_prim_fixed_lines: assert property (
        ##1 (prim_irq[14] == $past(spw1_irq) &&
             prim_irq[11] == $past(trace_irq) &&
             prim_irq[9] == $past(timer2_irq) &&
             prim_irq[8] == $past(timer1_irq) &&
             prim_irq[3] == $past(uart1_irq) &&
             prim_irq[2] == $past(uart2_irq) &&
             prim_irq[1] == $past(bus_err_irq) && !prim_irq[0]))
        else $error("primary fixed line mismatch");

    chk_pio_line_map: assert property (
        ##1 (prim_irq[7:4] == $past(pio_irq[3:0]) &&
             prim_irq[15] == $past(pio_irq[7])))
        else $error("parallel io line mismatch");

    chk_gpio_edge_pend: assert property (
        $rose(gpio_irq[23]) |-> ##2 sec_pending[31])
        else $error("port pin 23 edge not on line 31");

    chk_unused_lines: assert property (
        sec_pending[0] == 1'b0 && sec_pending[23:20] == 4'h0)
        else $error("unused secondary line pending");

    chk_adc_edge_pend: assert property (
        $rose(adc_ready) |-> ##2 sec_pending[4])
        else $error("converter ready not on line 4");

    chk_tick_edge_pend: assert property (
        $rose(spw1_tick) |-> ##2 sec_pending[16])
        else $error("link 1 tick not on line 16");

    chk_can_sync_pend: assert property (
        $rose(can_sync_received) |-> ##2 sec_pending[19])
        else $error("can sync received not on line 19");

    chk_rx_parity_pend: assert property (
        $rose(fifo_rx_parity_fault) |-> ##2 sec_pending[12])
        else $error("parity fault not on line 12");

    chk_tx_done_pend: assert property (
        $rose(fifo_tx_block_done) |-> ##2 sec_pending[6])
        else $error("transmit done not on line 6");

    chk_level_no_repend: assert property (
        spw0_irq [*2] ##1 (spw0_irq && sec_clear[13]) ##1
            spw0_irq [*2] |-> !sec_pending[13])
        else $error("held level re-latched without an edge");

    chk_prim_level_pass: assert property (
        ##1 (prim_irq[12] == $past(can_irq | pio_irq[5]) &&
             prim_irq[13] == $past(spw0_irq | pio_irq[6])))
        else $error("duplicated level source lost on primary");

    chk_second_line: assert property (
        (|(sec_pending & sec_mask)) && $stable(sec_mask) &&
            !(|sec_clear) |-> ##2 prim_irq[10])
        else $error("unmasked pending did not raise line 10");

    chk_set_over_clear: assert property (
        $rose(gpio_irq[16]) ##1 sec_clear[24] |-> ##1 sec_pending[24])
        else $error("clear beat a coinciding edge");

    // ----------------------------------------------------------------
    // Line map checks
    // ----------------------------------------------------------------
    chk_gpio_low_pend: assert property (
        $rose(gpio_irq[16]) |-> ##2 sec_pending[24])
        else $error("port pin 16 edge not on line 24");

    chk_gpio_mid_pend: assert property (
        $rose(gpio_irq[20]) |-> ##2 sec_pending[28])
        else $error("port pin 20 edge not on line 28");

    chk_dac_edge_pend: assert property (
        $rose(dac_ready) |-> ##2 sec_pending[5])
        else $error("converter ready not on line 5");

    chk_timer2_edge_pend: assert property (
        $rose(gtimer2_expired) |-> ##2 sec_pending[3])
        else $error("timer 2 expiry not on line 3");

    chk_timer1_edge_pend: assert property (
        $rose(gtimer1_expired) |-> ##2 sec_pending[2])
        else $error("timer 1 expiry not on line 2");

    chk_pulse_edge_pend: assert property (
        $rose(pulse_done) |-> ##2 sec_pending[1])
        else $error("pulse done not on line 1");

    chk_tick0_edge_pend: assert property (
        $rose(spw0_tick) |-> ##2 sec_pending[14])
        else $error("link 0 tick not on line 14");

    chk_link0_irq_pend: assert property (
        $rose(spw0_irq) |-> ##2 sec_pending[13])
        else $error("link 0 output not on line 13");

    chk_link1_irq_pend: assert property (
        $rose(spw1_irq) |-> ##2 sec_pending[15])
        else $error("link 1 output not on line 15");

    chk_can_irq_pend: assert property (
        $rose(can_irq) |-> ##2 sec_pending[17])
        else $error("can output not on line 17");

    chk_can_sent_pend: assert property (
        $rose(can_sync_sent) |-> ##2 sec_pending[18])
        else $error("can sync sent not on line 18");

    chk_rx_bus_pend: assert property (
        $rose(fifo_rx_bus_fault) |-> ##2 sec_pending[11])
        else $error("receive bus fault not on line 11");

    chk_rx_full_pend: assert property (
        $rose(fifo_rx_ring_full) |-> ##2 sec_pending[10])
        else $error("receive ring full not on line 10");

    chk_rx_done_pend: assert property (
        $rose(fifo_rx_block_done) |-> ##2 sec_pending[9])
        else $error("receive done not on line 9");

    chk_tx_bus_pend: assert property (
        $rose(fifo_tx_bus_fault) |-> ##2 sec_pending[8])
        else $error("transmit bus fault not on line 8");

    chk_tx_empty_pend: assert property (
        $rose(fifo_tx_ring_empty) |-> ##2 sec_pending[7])
        else $error("transmit ring empty not on line 7");

    chk_shared_line10: assert property (
        pio_irq[4] |-> ##1 prim_irq[10])
        else $error("parallel io bit 4 not on line 10");

    cov_adc_to_line10: cover property (
        $rose(adc_ready) && sec_mask[4] ##[1:4] prim_irq[10]);
    cov_set_and_clear: cover property (
        $rose(gpio_irq[16]) ##1 sec_clear[24] ##1 sec_pending[24]);
    cov_clear_pending: cover property (
        sec_pending[9] && sec_clear[9] ##1 !sec_pending[9]);
    cov_spw_both: cover property (
        spw0_irq ##2 sec_pending[13] && prim_irq[13]);

endmodule

// ### irsr_sw_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Handler software seen from the secondary controller
// ----------------------------------------------------------------
module irsr_sw_model (
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        clr_go,
    input  wire logic [31:0] clr_bits,
    input  wire logic [31:0] src_busy,
    input  wire logic        careless,
    output logic      [31:0] sec_clear
);
    // level lines cleared only when idle unless careless is set
    // Careless mode exists so a scenario can lose an event on purpose
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sec_clear <= 32'h0000_0000;
        end else if (clr_go) begin
            sec_clear <= clr_bits & (careless ? 32'hFFFF_FFFF : ~src_busy);
        end else begin
            sec_clear <= 32'h0000_0000;
        end
    end
endmodule

// ### irsr_top_tb_top.sv
`timescale 1ns/1ps

module irsr_top_tb_top;
    // ----------------------------------------------------------------
    // Stimulus and observation
    // ----------------------------------------------------------------
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  pio = 8'h00;
    logic [15:0] prim_in = 16'h0000;
    logic [31:0] sec_in = 32'h0000_0000;
    logic [15:0] gpio_lo = 16'h0000;
    logic [31:0] sec_mask = 32'h0000_0000;
    logic        clr_go = 1'b0;
    logic [31:0] clr_bits = 32'h0000_0000;
    logic        careless = 1'b0;
    logic [31:0] src_busy;
    logic [31:0] sec_clear;
    logic [31:0] sec_pending;
    logic [15:0] prim_irq;
    int          miscompares = 0;
    int          comparisons = 0;
    int          lines[6] = '{1, 2, 3, 8, 9, 11};
    int          lvl[3] = '{13, 15, 17};

    always #2.5 sys_clk = ~sys_clk;
    // Only the three level sources can be busy
    assign src_busy = sec_in & 32'h0002_A000;

    irsr_top i_dut (
        .sys_clk(sys_clk), .rstn(rstn), .pio_irq(pio),
        .spw1_irq(sec_in[15]), .spw0_irq(sec_in[13]), .can_irq(sec_in[17]),
        .trace_irq(prim_in[11]), .timer2_irq(prim_in[9]),
        .timer1_irq(prim_in[8]), .uart1_irq(prim_in[3]),
        .uart2_irq(prim_in[2]), .bus_err_irq(prim_in[1]),
        .gpio_irq({sec_in[31:24], gpio_lo}),
        .can_sync_received(sec_in[19]), .can_sync_sent(sec_in[18]),
        .spw1_tick(sec_in[16]), .spw0_tick(sec_in[14]),
        .fifo_rx_parity_fault(sec_in[12]), .fifo_rx_bus_fault(sec_in[11]),
        .fifo_rx_ring_full(sec_in[10]), .fifo_rx_block_done(sec_in[9]),
        .fifo_tx_bus_fault(sec_in[8]), .fifo_tx_ring_empty(sec_in[7]),
        .fifo_tx_block_done(sec_in[6]), .dac_ready(sec_in[5]),
        .adc_ready(sec_in[4]), .gtimer2_expired(sec_in[3]),
        .gtimer1_expired(sec_in[2]), .pulse_done(sec_in[1]),
        .sec_mask(sec_mask), .sec_clear(sec_clear),
        .prim_irq(prim_irq), .sec_pending(sec_pending)
    );

    irsr_sw_model i_sw (
        .sys_clk(sys_clk), .rstn(rstn), .clr_go(clr_go),
        .clr_bits(clr_bits), .src_busy(src_busy), .careless(careless),
        .sec_clear(sec_clear)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic complete_run;
        if (miscompares == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic [15:0] exp_prim(input logic [7:0] p,
            input logic [15:0] pi, input logic [31:0] si);
        logic [15:0] e;
        e = pi & 16'h0B0E;
        e[7:4] = p[3:0];
        e[10] = p[4];
        e[12] = p[5] | si[17];
        e[13] = p[6] | si[13];
        e[14] = si[15];
        e[15] = p[7];
        return e;
    endfunction

    task automatic clear_all;
        @(posedge sys_clk);
        clr_go <= 1'b1;
        clr_bits <= 32'hFFFF_FFFF;
        careless <= 1'b1;
        @(posedge sys_clk);
        clr_go <= 1'b0;
        careless <= 1'b0;
        tick(2);
    endtask

    task automatic apply_prim(input logic [7:0] p, input logic [15:0] pi,
            input logic [31:0] si);
        @(posedge sys_clk);
        pio <= p;
        prim_in <= pi;
        sec_in <= si;
        tick(2);
        chk({16'h0000, prim_irq}, {16'h0000, exp_prim(p, pi, si)});
        @(posedge sys_clk);
        pio <= 8'h00;
        prim_in <= 16'h0000;
        sec_in <= 32'h0000_0000;
        tick(2);
        chk({16'h0000, prim_irq}, 32'h0000_0000);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic prim_map;
        for (int i = 0; i < 8; i++) apply_prim(8'h01 << i, 16'h0000, 32'h0);
        foreach (lines[k]) apply_prim(8'h00, 16'h0001 << lines[k], 32'h0);
        foreach (lvl[k]) apply_prim(8'h00, 16'h0000, 32'h1 << lvl[k]);
        clear_all;
    endtask

    task automatic sec_map;
        for (int i = 0; i < 32; i++) begin
            // Single pulses only: port pins are edge programmed
            @(posedge sys_clk);
            sec_in <= 32'h1 << i;
            gpio_lo <= 16'hFFFF;
            @(posedge sys_clk);
            sec_in <= 32'h0000_0000;
            gpio_lo <= 16'h0000;
            tick(2);
            chk(sec_pending, (32'h1 << i) & 32'hFF0F_FFFE);
            clear_all;
            chk(sec_pending, 32'h0000_0000);
        end
    endtask

    task automatic level_loss;
        @(posedge sys_clk);
        sec_in[13] <= 1'b1;
        tick(3);
        chk(sec_pending, 32'h0000_2000);
        clear_all;
        tick(4);
        chk(sec_pending, 32'h0000_0000);
        chk({16'h0000, prim_irq}, 32'h0000_2000);
        @(posedge sys_clk);
        sec_in[13] <= 1'b0;
        @(posedge sys_clk);
        sec_in[13] <= 1'b1;
        tick(3);
        chk(sec_pending, 32'h0000_2000);
        @(posedge sys_clk);
        clr_go <= 1'b1;
        @(posedge sys_clk);
        clr_go <= 1'b0;
        tick(2);
        chk(sec_pending, 32'h0000_2000);
        @(posedge sys_clk);
        sec_in[13] <= 1'b0;
        clear_all;
    endtask

    task automatic set_vs_clear;
        @(posedge sys_clk);
        sec_in[24] <= 1'b1;
        clr_go <= 1'b1;
        careless <= 1'b1;
        @(posedge sys_clk);
        sec_in[24] <= 1'b0;
        clr_go <= 1'b0;
        tick(2);
        chk(sec_pending, 32'h0100_0000);
        clear_all;
        chk(sec_pending, 32'h0000_0000);
    endtask

    task automatic mask_route;
        int n;
        n = 0;
        @(posedge sys_clk);
        sec_mask <= 32'h0000_0010;
        sec_in[4] <= 1'b1;
        @(posedge sys_clk);
        sec_in[4] <= 1'b0;
        tick(1);
        chk(sec_pending, 32'h0000_0010);
        chk({16'h0000, prim_irq}, 32'h0000_0000);
        while (prim_irq[10] !== 1'b1 && n < 8) begin
            tick(1);
            n++;
        end
        if (n >= 8) begin
            miscompares++;
            complete_run;
        end
        chk(n, 1);
        @(posedge sys_clk);
        sec_mask <= 32'h0000_0000;
        tick(2);
        chk({16'h0000, prim_irq}, 32'h0000_0000);
        chk(sec_pending, 32'h0000_0010);
        clear_all;
        chk(sec_pending, 32'h0000_0000);
    endtask

    initial begin
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        tick(1);
        chk({16'h0000, prim_irq}, 32'h0000_0000);
        prim_map;
        sec_map;
        level_loss;
        mask_route;
        set_vs_clear;
        complete_run;
    end
endmodule
